// *** drl_pkg.sv ***
// shared types and constants for the differential restraint logic
package drl_pkg;
  localparam int CUR_W = 16;
  localparam int PCT_W = 8;
  localparam int MS_W = 16;
  localparam int PHASES = 3;
  // one millisecond tick at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYCLES = CLK_MHZ * MS_TICK_US;
  // lockout after stabilization ends, in milliseconds
  localparam logic [MS_W-1:0] LOCKOUT_MS = 16'h03e8;
  // differential current at or below this counts as zero (per-unit, 8 fraction bits)
  localparam logic [CUR_W-1:0] ID_ZERO_LEVEL = 16'h0008;
  // 1/sqrt(3) with 16 fraction bits
  localparam logic [16:0] INV_SQRT3_Q16 = 17'h093cd;
  localparam logic [CUR_W-1:0] CUR_RESET = 16'h0000;
  localparam logic [MS_W-1:0] CNT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SCH_STAR = 3'b000,
    SCH_DELTA = 3'b001,
    SCH_ZIGZAG = 3'b010,
    SCH_STAR_GND = 3'b011,
    SCH_ZIGZAG_GND = 3'b100
  } drl_scheme_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_LOCK = 2'b10
  } drl_stab_state_t;

  typedef struct packed {
    logic signed [CUR_W-1:0] re;
    logic signed [CUR_W-1:0] im;
  } drl_phasor_t;

  typedef struct packed {
    logic [CUR_W-1:0] differential_current;
    logic [CUR_W-1:0] restraint_current;
    logic [PCT_W-1:0] second_pct;
    logic [PCT_W-1:0] fourth_pct;
    logic [PCT_W-1:0] fifth_pct;
    logic zero_cross;
  } drl_meas_t;

  typedef struct packed {
    logic [PCT_W-1:0] second_harmonic_transient_threshold;
    logic [PCT_W-1:0] fifth_harmonic_transient_threshold;
    logic [PCT_W-1:0] second_harmonic_stationary_threshold;
    logic [PCT_W-1:0] fourth_harmonic_stationary_threshold;
    logic [PCT_W-1:0] fifth_harmonic_stationary_threshold;
  } drl_thresh_t;
endpackage

// *** drl_sat_stab.sv ***
// per-phase saturation stabilizer: zero-crossing fault check, hold timer, lockout
`timescale 1ns/1ps
module drl_sat_stab (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic ms_tick_in,
  input wire logic enable_in,
  input wire logic zero_cross_in,
  input wire logic [drl_pkg::CUR_W-1:0] differential_current_in,
  input wire logic [drl_pkg::CUR_W-1:0] restraint_current_in,
  input wire logic [drl_pkg::MS_W-1:0] saturation_max_hold_time_in,
  output logic active_out
);
  import drl_pkg::*;

  drl_stab_state_t state_ff, nxt_state;
  logic [MS_W-1:0] cnt_ff, nxt_cnt;
  logic [CUR_W-1:0] id_prev_ff, is_prev_ff;
  logic int_prev_ff, nxt_int_prev;

  wire is_rise = restraint_current_in > is_prev_ff;
  wire id_zero = differential_current_in <= ID_ZERO_LEVEL;
  wire id_rise = differential_current_in > id_prev_ff;
  wire external_fault = zero_cross_in & is_rise & id_zero;
  wire internal_fault = zero_cross_in & is_rise & id_rise & !id_zero;
  wire internal_twice = internal_fault & int_prev_ff;
  wire hold_expired = cnt_ff >= saturation_max_hold_time_in;
  wire lock_done = cnt_ff >= LOCKOUT_MS - 16'h0001;

  // a crossing without an internal fault breaks the run of two
  assign nxt_int_prev = zero_cross_in ? internal_fault : int_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        // internal faults never start a hold, so trips are not delayed
        if (enable_in && external_fault && !internal_fault) begin
          nxt_state = ST_HOLD;
          nxt_cnt = CNT_RESET;
        end
      end
      ST_HOLD: begin
        // an evolving internal fault needs two crossings, hence 1..2 cycles of delay
        if (internal_twice || hold_expired || !enable_in) begin
          nxt_state = ST_LOCK;
          nxt_cnt = CNT_RESET;
        end else if (ms_tick_in) begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      ST_LOCK: begin
        if (ms_tick_in) begin
          if (lock_done) begin
            nxt_state = ST_IDLE;
            nxt_cnt = CNT_RESET;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_RESET;
      id_prev_ff <= CUR_RESET;
      is_prev_ff <= CUR_RESET;
      int_prev_ff <= 1'b0;
      active_out <= 1'b0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      int_prev_ff <= nxt_int_prev;
      active_out <= (nxt_state == ST_HOLD);
      if (zero_cross_in) begin
        id_prev_ff <= differential_current_in;
        is_prev_ff <= restraint_current_in;
      end
    end
  end
endmodule

// *** drl_restraint.sv ***
// differential restraint top: zero-sequence removal, harmonic and saturation restraint
//
// What this block does
// - subtract each winding's zero-sequence current, chosen by its connection setting
// - grounded-neutral schemes mean neutral tied to ground, enabling zero-sequence flow
// - while restraining, add constant offset to restraining quantity, raising threshold
// - restraint offset is a setting in multiples of base current
// - harmonic triggers fire only when enabled and percentage exceeds threshold
// - saturation trigger fires only when enabled and external fault with saturation seen
// - setting chooses per-phase restraint or blocking all three phases
// - second and fifth harmonics use transient thresholds inside inrush window
// - after window, restraint holds while any stationary harmonic threshold exceeded
// - at each zero crossing, restraint rising with zero differential starts restraint
// - two consecutive crossings with both currents rising remove restraint
// - stabilizer never starts restraint during an internal fault
// - evolving external-to-internal fault may delay trip by one to two cycles
// - maximum hold timer starts at trigger and removes restraint on expiry
// - after stabilization ends, no new stabilization for one second
// - base current per winding from rated power and voltage; winding one is reference
`timescale 1ns/1ps
module drl_restraint #(
  parameter int MS_CYCLES = drl_pkg::MS_TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire drl_pkg::drl_phasor_t [drl_pkg::PHASES-1:0] winding_one_phasor_in,
  input wire drl_pkg::drl_phasor_t [drl_pkg::PHASES-1:0] winding_two_phasor_in,
  input wire drl_pkg::drl_scheme_t winding_one_scheme_in,
  input wire drl_pkg::drl_scheme_t winding_two_scheme_in,
  input wire drl_pkg::drl_meas_t [drl_pkg::PHASES-1:0] meas_in,
  input wire drl_pkg::drl_thresh_t thresh_in,
  input wire logic second_harmonic_trigger_enable_in,
  input wire logic fourth_harmonic_trigger_enable_in,
  input wire logic fifth_harmonic_trigger_enable_in,
  input wire logic saturation_trigger_enable_in,
  input wire logic cross_block_in,
  input wire logic [drl_pkg::CUR_W-1:0] restraint_offset_in,
  input wire logic energize_in,
  input wire logic [drl_pkg::MS_W-1:0] inrush_window_ms_in,
  input wire logic [drl_pkg::MS_W-1:0] saturation_max_hold_time_in,
  input wire logic [drl_pkg::CUR_W-1:0] rated_apparent_power_in,
  input wire logic [drl_pkg::CUR_W-1:0] winding_one_rated_voltage_in,
  input wire logic [drl_pkg::CUR_W-1:0] winding_two_rated_voltage_in,
  output drl_pkg::drl_phasor_t [drl_pkg::PHASES-1:0] winding_one_comp_out,
  output drl_pkg::drl_phasor_t [drl_pkg::PHASES-1:0] winding_two_comp_out,
  output logic [drl_pkg::PHASES-1:0] restrain_out,
  output logic [drl_pkg::PHASES-1:0] saturation_active_out,
  output logic [drl_pkg::PHASES*drl_pkg::CUR_W-1:0] restraint_adj_out,
  output logic transient_window_out,
  output logic [drl_pkg::CUR_W-1:0] base_current_w1_out,
  output logic [drl_pkg::CUR_W-1:0] base_current_w2_out
);
  import drl_pkg::*;

  logic [$clog2(MS_CYCLES)-1:0] tick_cnt_ff;
  logic ms_tick_ff;
  logic [MS_W-1:0] win_cnt_ff;
  logic [PHASES-1:0] sat_active;
  logic [PHASES-1:0] phase_trig;

  // millisecond prescaler shared by all timers
  wire tick_wrap = tick_cnt_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);

  wire w1_grounded = (winding_one_scheme_in == SCH_STAR_GND) ||
                     (winding_one_scheme_in == SCH_ZIGZAG_GND);
  wire w2_grounded = (winding_two_scheme_in == SCH_STAR_GND) ||
                     (winding_two_scheme_in == SCH_ZIGZAG_GND);

  // zero-sequence: third of the phase sum; widened so the sum cannot overflow
  wire signed [CUR_W+1:0] w1_sum_re = winding_one_phasor_in[0].re +
    winding_one_phasor_in[1].re + winding_one_phasor_in[2].re;
  wire signed [CUR_W+1:0] w1_sum_im = winding_one_phasor_in[0].im +
    winding_one_phasor_in[1].im + winding_one_phasor_in[2].im;
  wire signed [CUR_W+1:0] w2_sum_re = winding_two_phasor_in[0].re +
    winding_two_phasor_in[1].re + winding_two_phasor_in[2].re;
  wire signed [CUR_W+1:0] w2_sum_im = winding_two_phasor_in[0].im +
    winding_two_phasor_in[1].im + winding_two_phasor_in[2].im;
  wire signed [CUR_W-1:0] w1_zero_re = w1_grounded ? CUR_W'(w1_sum_re / 3) : '0;
  wire signed [CUR_W-1:0] w1_zero_im = w1_grounded ? CUR_W'(w1_sum_im / 3) : '0;
  wire signed [CUR_W-1:0] w2_zero_re = w2_grounded ? CUR_W'(w2_sum_re / 3) : '0;
  wire signed [CUR_W-1:0] w2_zero_im = w2_grounded ? CUR_W'(w2_sum_im / 3) : '0;

  // base current: power / (sqrt3 * voltage), 8 fraction bits kept
  wire [32:0] pow_scaled = rated_apparent_power_in * INV_SQRT3_Q16;
  wire [32:0] w1_div = (winding_one_rated_voltage_in == '0) ? '0 :
                       (pow_scaled >> 8) / winding_one_rated_voltage_in;
  wire [32:0] w2_div = (winding_two_rated_voltage_in == '0) ? '0 :
                       (pow_scaled >> 8) / winding_two_rated_voltage_in;

  wire window_done = ms_tick_ff && (win_cnt_ff >= inrush_window_ms_in);
  wire all_trig = |phase_trig;

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      wire transient = transient_window_out;
      wire [PCT_W-1:0] h2_thr = transient ? thresh_in.second_harmonic_transient_threshold :
                                thresh_in.second_harmonic_stationary_threshold;
      wire [PCT_W-1:0] h5_thr = transient ? thresh_in.fifth_harmonic_transient_threshold :
                                thresh_in.fifth_harmonic_stationary_threshold;
      wire h2_trig = second_harmonic_trigger_enable_in && (meas_in[p].second_pct > h2_thr);
      wire h4_trig = fourth_harmonic_trigger_enable_in &&
        (meas_in[p].fourth_pct > thresh_in.fourth_harmonic_stationary_threshold);
      wire h5_trig = fifth_harmonic_trigger_enable_in && (meas_in[p].fifth_pct > h5_thr);
      assign phase_trig[p] = h2_trig | h4_trig | h5_trig | sat_active[p];
      wire restrain = cross_block_in ? all_trig : phase_trig[p];
      // saturating add keeps the raised threshold from wrapping to a low value
      wire [CUR_W:0] adj_sum = {1'b0, meas_in[p].restraint_current} +
                               {1'b0, restraint_offset_in};
      wire [CUR_W-1:0] adj = adj_sum[CUR_W] ? '1 : adj_sum[CUR_W-1:0];

      drl_sat_stab drl_sat_stab_i (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .ms_tick_in(ms_tick_ff),
        .enable_in(saturation_trigger_enable_in),
        .zero_cross_in(meas_in[p].zero_cross),
        .differential_current_in(meas_in[p].differential_current),
        .restraint_current_in(meas_in[p].restraint_current),
        .saturation_max_hold_time_in(saturation_max_hold_time_in),
        .active_out(sat_active[p])
      );

      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          restrain_out[p] <= 1'b0;
          saturation_active_out[p] <= 1'b0;
          restraint_adj_out[p*CUR_W +: CUR_W] <= CUR_RESET;
          winding_one_comp_out[p] <= '0;
          winding_two_comp_out[p] <= '0;
        end else if (ce_in) begin
          restrain_out[p] <= restrain;
          saturation_active_out[p] <= sat_active[p];
          restraint_adj_out[p*CUR_W +: CUR_W] <=
            restrain ? adj : meas_in[p].restraint_current;
          winding_one_comp_out[p].re <= winding_one_phasor_in[p].re - w1_zero_re;
          winding_one_comp_out[p].im <= winding_one_phasor_in[p].im - w1_zero_im;
          winding_two_comp_out[p].re <= winding_two_phasor_in[p].re - w2_zero_re;
          winding_two_comp_out[p].im <= winding_two_phasor_in[p].im - w2_zero_im;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tick_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
      win_cnt_ff <= CNT_RESET;
      transient_window_out <= 1'b0;
      base_current_w1_out <= CUR_RESET;
      base_current_w2_out <= CUR_RESET;
    end else if (ce_in) begin
      tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
      ms_tick_ff <= tick_wrap;
      if (energize_in) begin
        win_cnt_ff <= CNT_RESET;
        transient_window_out <= 1'b1;
      end else if (transient_window_out && window_done) begin
        transient_window_out <= 1'b0;
      end else if (transient_window_out && ms_tick_ff) begin
        win_cnt_ff <= win_cnt_ff + 16'h0001;
      end
      base_current_w1_out <= (|w1_div[32:CUR_W]) ? '1 : w1_div[CUR_W-1:0];
      base_current_w2_out <= (|w2_div[32:CUR_W]) ? '1 : w2_div[CUR_W-1:0];
    end
  end
endmodule

// *** drl_restraint_assertions.sv ***
// assertion checker on the differential restraint top ports
`timescale 1ns/1ps
module drl_restraint_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire drl_pkg::drl_meas_t [drl_pkg::PHASES-1:0] meas_in,
  input wire drl_pkg::drl_thresh_t thresh_in,
  input wire logic second_harmonic_trigger_enable_in,
  input wire logic fourth_harmonic_trigger_enable_in,
  input wire logic fifth_harmonic_trigger_enable_in,
  input wire logic saturation_trigger_enable_in,
  input wire logic cross_block_in,
  input wire logic [drl_pkg::CUR_W-1:0] restraint_offset_in,
  input wire logic energize_in,
  input wire logic [drl_pkg::PHASES-1:0] restrain_out,
  input wire logic [drl_pkg::PHASES-1:0] saturation_active_out,
  input wire logic [drl_pkg::PHASES*drl_pkg::CUR_W-1:0] restraint_adj_out,
  input wire logic transient_window_out
);
  import drl_pkg::*;
  // lock runs 1000 ticks; tick phase is unknown, so allow one tick of slack
  localparam int LOCK_MIN = 999 * MS_CYCLES;
  // no saturation term: offsets used here keep the sum well below full scale
  wire logic [15:0] adj_exp = meas_in[0].restraint_current + restraint_offset_in;
  logic [15:0] lock_cnt_ff;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) lock_cnt_ff <= 16'h0000;
    else if ($fell(saturation_active_out[0])) lock_cnt_ff <= 16'h0001;
    else if (lock_cnt_ff != 16'h0000) lock_cnt_ff <= lock_cnt_ff + 16'h0001;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence all_off_s;
    !second_harmonic_trigger_enable_in && !fourth_harmonic_trigger_enable_in &&
      !fifth_harmonic_trigger_enable_in && !saturation_trigger_enable_in;
  endsequence
  // a crossing with differential current clearly above zero can only be internal
  sequence int_cross_s;
    meas_in[0].zero_cross && meas_in[0].differential_current > ID_ZERO_LEVEL;
  endsequence
  sequence h4_over_s(int p);
    ce_in && fourth_harmonic_trigger_enable_in &&
      meas_in[p].fourth_pct > thresh_in.fourth_harmonic_stationary_threshold;
  endsequence
  adj_raised_a: assert property (
    $past(ce_in) && !$past(rst_in) && restrain_out[0] |->
      restraint_adj_out[15:0] == $past(adj_exp))
    else $error("raised restraint quantity wrong");
  adj_plain_a: assert property (
    $past(ce_in) && !$past(rst_in) && !restrain_out[0] |->
      restraint_adj_out[15:0] == $past(meas_in[0].restraint_current))
    else $error("plain restraint quantity wrong");
  h4_fires_a: assert property (h4_over_s(0) |=> restrain_out[0])
    else $error("fourth harmonic did not restrain");
  all_off_a: assert property (all_off_s [*4] |=> restrain_out == 3'b000)
    else $error("restraint without any enabled trigger");
  cross_all_a: assert property (
    h4_over_s(1) and cross_block_in |=> restrain_out == 3'b111)
    else $error("cross block did not restrain all phases");
  window_open_a: assert property (ce_in && energize_in |=> transient_window_out)
    else $error("inrush window not opened");
  int_no_start_a: assert property (
    int_cross_s ##1 !saturation_active_out[0] |=> !saturation_active_out[0])
    else $error("stabilizer started on an internal fault");
  sat_flag_a: assert property (saturation_active_out[0] |-> restrain_out[0])
    else $error("stabilizer hold without restraint");
  lockout_a: assert property (
    lock_cnt_ff != 16'h0000 && lock_cnt_ff < LOCK_MIN |-> !saturation_active_out[0])
    else $error("stabilizer retriggered inside lockout");
endmodule
bind drl_restraint drl_restraint_checker #(.MS_CYCLES(MS_CYCLES)) drl_restraint_checker_i (
  .core_clk_in, .rst_in, .ce_in, .meas_in, .thresh_in, .second_harmonic_trigger_enable_in,
  .fourth_harmonic_trigger_enable_in, .fifth_harmonic_trigger_enable_in,
  .saturation_trigger_enable_in, .cross_block_in, .restraint_offset_in, .energize_in,
  .restrain_out, .saturation_active_out, .restraint_adj_out, .transient_window_out);

// *** drl_meas_model.sv ***
// measurement front end model: phase currents, harmonic levels, zero crossings
`timescale 1ns/1ps
module drl_meas_model (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] harm_phase_in,
  input wire logic [drl_pkg::PCT_W-1:0] harm_pct_in,
  input wire logic [2:0] harm_sel_in,
  output drl_pkg::drl_meas_t [drl_pkg::PHASES-1:0] meas_out
);
  import drl_pkg::*;
  // mode 0 quiet, 1 external fault, 2 internal fault; restraint only ever grows
  logic [7:0] gap_ff;
  logic [CUR_W-1:0] is_ff;
  logic [CUR_W-1:0] id_ff;
  wire logic zc = (gap_ff == 8'h00) && (mode_in != 2'b00);
  always_ff @(posedge core_clk_in) begin
    if (rst_in || mode_in == 2'b00 || zc) gap_ff <= 8'h13;
    else gap_ff <= gap_ff - 8'h01;
    if (rst_in) is_ff <= 16'h0100;
    else if (zc) is_ff <= is_ff + 16'h0040;
    if (rst_in) id_ff <= 16'h0010;
    else if (zc && mode_in == 2'b10) id_ff <= id_ff + 16'h0010;
  end
  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      meas_out[p].restraint_current = is_ff;
      meas_out[p].differential_current = (mode_in == 2'b10) ? id_ff : 16'h0000;
      meas_out[p].second_pct = (p == harm_phase_in && harm_sel_in[0]) ? harm_pct_in : 8'h00;
      meas_out[p].fourth_pct = (p == harm_phase_in && harm_sel_in[1]) ? harm_pct_in : 8'h00;
      meas_out[p].fifth_pct = (p == harm_phase_in && harm_sel_in[2]) ? harm_pct_in : 8'h00;
      meas_out[p].zero_cross = zc;
    end
  end
endmodule

// *** drl_restraint_bench.sv ***
// self-checking bench for the differential restraint top
`timescale 1ns/1ps
module drl_restraint_bench;
  import drl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic ene = 1'b0;
  logic xb = 1'b0;
  logic any = 1'b0;
  logic [3:0] en = 4'h0;
  logic [1:0] mode = 2'b00;
  logic [1:0] hph = 2'b00;
  logic [2:0] hsel = 3'b000;
  logic [7:0] hpct = 8'h00;
  logic [15:0] hold = 16'h0003;
  logic [15:0] pw = 16'd1000;
  logic [15:0] v2 = 16'h0000;
  drl_scheme_t s1 = SCH_STAR;
  drl_scheme_t s2 = SCH_STAR;
  drl_phasor_t [PHASES-1:0] w = {16'sd100, 16'sd10, -16'sd200, 16'sd20, -16'sd1, 16'sd31};
  drl_meas_t [PHASES-1:0] meas;
  drl_phasor_t [PHASES-1:0] c1, c2;
  logic [2:0] rs, sa;
  logic [47:0] adj;
  logic tw;
  logic [15:0] b1, b2;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  drl_restraint #(.MS_CYCLES(10)) drl_restraint_i (.core_clk_in(clk), .rst_in(rst), .ce_in(ce),
    .winding_one_phasor_in(w), .winding_two_phasor_in(w), .winding_one_scheme_in(s1),
    .winding_two_scheme_in(s2), .meas_in(meas), .thresh_in({8'h0a, 8'h0a, 8'h14, 8'h14, 8'h14}),
    .second_harmonic_trigger_enable_in(en[0]), .fourth_harmonic_trigger_enable_in(en[1]),
    .fifth_harmonic_trigger_enable_in(en[2]), .saturation_trigger_enable_in(en[3]),
    .cross_block_in(xb), .restraint_offset_in(16'h0080), .energize_in(ene),
    .inrush_window_ms_in(16'h0002), .saturation_max_hold_time_in(hold),
    .rated_apparent_power_in(pw), .winding_one_rated_voltage_in(16'd100),
    .winding_two_rated_voltage_in(v2), .winding_one_comp_out(c1), .winding_two_comp_out(c2),
    .restrain_out(rs), .saturation_active_out(sa), .restraint_adj_out(adj),
    .transient_window_out(tw), .base_current_w1_out(b1), .base_current_w2_out(b2));
  drl_meas_model drl_meas_model_i (.core_clk_in(clk), .rst_in(rst), .mode_in(mode),
    .harm_phase_in(hph), .harm_pct_in(hpct), .harm_sel_in(hsel), .meas_out(meas));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // run n cycles noting any stabilizer hold, or stop early once sa[0] shows stop_v
  task automatic run(input int n, input logic stop_on, input logic stop_v);
    any = 1'b0;
    for (int i = 0; i < n && !(stop_on && sa[0] === stop_v); i++) begin
      step(1);
      any |= sa[0];
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic t_comp();
    drl_phasor_t e;
    for (int k = 0; k < 5; k++) begin
      s1 = drl_scheme_t'(k);
      s2 = drl_scheme_t'(4 - k);
      step(1);
      // zero sequence is -101/3 and 61/3, truncated toward zero
      for (int p = 0; p < PHASES; p++) begin
        e = {w[p].re + 16'sd33, w[p].im - 16'sd20};
        check(c1[p], (k > 2) ? e : w[p]);
        check(c2[p], (k < 2) ? e : w[p]);
      end
    end
    check(b1, 16'h05c6);
    check(b2, 16'h0000);
    v2 = 16'd10;
    step(1);
    check(b2, 16'h39bc);
    // clock enable low must freeze the registered outputs
    ce = 1'b0;
    v2 = 16'd20;
    step(3);
    check(b2, 16'h39bc);
    ce = 1'b1;
    step(1);
    check(b2, 16'h1cde);
  endtask
  task automatic t_harm();
    for (int k = 0; k < 3; k++) begin
      en = 4'(1 << k);
      hsel = 3'(1 << k);
      hpct = 8'h14;
      step(2);
      check({rs, adj[15:0]}, {3'b000, 16'h0100});
      hpct = 8'h15;
      step(2);
      check({rs, adj[15:0]}, {3'b001, 16'h0180});
      en = 4'h0;
      step(2);
      check(rs, 3'b000);
    end
    en = 4'h2;
    hsel = 3'b010;
    hph = 2'b01;
    step(2);
    check(rs, 3'b010);
    xb = 1'b1;
    step(2);
    check(rs, 3'b111);
    check(adj, {3{16'h0180}});
    xb = 1'b0;
    hph = 2'b00;
    en = 4'h1;
    hsel = 3'b001;
    hpct = 8'h10;
    ene = 1'b1;
    step(1);
    ene = 1'b0;
    step(2);
    check({tw, rs}, 4'b1001);
    step(40);
    check({tw, rs}, 4'b0000);
    hpct = 8'h15;
    step(2);
    check(rs, 3'b001);
    en = 4'h0;
  endtask
  task automatic t_sat();
    en = 4'h8;
    mode = 2'b10;
    run(200, 1'b0, 1'b0);
    check(any, 1'b0);
    en = 4'h0;
    mode = 2'b01;
    run(100, 1'b0, 1'b0);
    check(any, 1'b0);
    en = 4'h8;
    run(60, 1'b1, 1'b1);
    check({sa[0], rs[0]}, 2'b11);
    run(80, 1'b1, 1'b0);
    check(sa[0], 1'b0);
    hold = 16'd100;
    run(9000, 1'b0, 1'b0);
    check(any, 1'b0);
    run(1500, 1'b1, 1'b1);
    check(sa[0], 1'b1);
    mode = 2'b10;
    run(60, 1'b1, 1'b0);
    check({sa[0], rs[0]}, 2'b00);
  endtask
  initial begin
    step(12);
    rst = 1'b0;
    check({rs, sa, tw}, 7'h00);
    check(adj, 48'h0);
    t_comp();
    t_harm();
    t_sat();
    finish_test();
  end
endmodule
